// file: include/cbt_pkg.sv
/*
 * Shared constants and types for the CAN bit timing and message object access block.
 * Assumes one 25 MHz core clock; every user writes package::name explicitly.
 */
package cbt_pkg;

	// Register addresses on the special function register port.
	localparam logic [7:0] ADDR_PAGE = 8'hB1;
	localparam logic [7:0] ADDR_STATUS = 8'hB2;
	localparam logic [7:0] ADDR_CONTROL = 8'hB3;
	localparam logic [7:0] ADDR_BT_JUMP = 8'hB5;
	localparam logic [7:0] ADDR_BT_PHASE = 8'hB6;
	localparam logic [7:0] ADDR_DATA = 8'hFA;
	localparam logic [7:0] ADDR_ENABLE_HI = 8'hCE;
	localparam logic [7:0] ADDR_ENABLE_LO = 8'hCF;

	// Object store dimensions.
	localparam int NUM_OBJECTS = 15;
	localparam int DATA_BYTES = 8;
	localparam logic [3:0] LAST_OBJECT = 4'hE;

	// Values after reset.
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [5:0] DIV_RESET = 6'h00;
	localparam logic [3:0] COUNT_RESET = 4'h0;
	localparam logic [2:0] EXT_RESET = 3'h0;

	// Object configuration codes.
	typedef enum logic [1:0] {
		CFG_DISABLE = 2'h0,
		CFG_TRANSMIT = 2'h1,
		CFG_RECEIVE = 2'h2,
		CFG_RX_BUFFER = 2'h3
	} cbt_config_type;

	// Page select register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic [3:0] object_number;
		logic increment_disable;
		logic [2:0] byte_index;
	} cbt_page_type;

	// Per-object control and length register layout.
	typedef struct packed {
		cbt_config_type object_configuration;
		logic reply_valid;
		logic extended_id;
		logic [3:0] length_code;
	} cbt_control_type;

	// Per-object status flags, bit 7 down to bit 0.
	typedef struct packed {
		logic length_warning;
		logic transmit_done;
		logic receive_done;
		logic bit_error_flag;
		logic stuff_error_flag;
		logic checksum_error_flag;
		logic form_error_flag;
		logic ack_error_flag;
	} cbt_status_type;

	// Jump width and propagation register layout.
	typedef struct packed {
		logic rsv_hi;
		logic [1:0] jump_width_field;
		logic rsv_mid;
		logic [2:0] propagation_field;
		logic rsv_lo;
	} cbt_jump_type;

	// Phase segments and sampling register layout.
	typedef struct packed {
		logic rsv_hi;
		logic [2:0] phase_two_field;
		logic [2:0] phase_one_field;
		logic sample_type;
	} cbt_phase_type;

	// One special function register access.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cbt_sfr_type;

	// Completion report from the frame engine for one object.
	typedef struct packed {
		logic valid;
		logic [3:0] object_number;
		logic rx_done;
		logic tx_done;
		logic [4:0] errors;
		logic [3:0] rx_length;
	} cbt_event_type;

	// Segments of one nominal bit.
	typedef enum logic [1:0] {
		SEG_SYNC,
		SEG_PROP,
		SEG_PH1,
		SEG_PH2
	} cbt_seg_type;

endpackage

// file: logic/cbt_sync.sv
/*
 * Two flip-flop synchroniser for the CAN receive pin.
 * Assumes the pin idles recessive (high) and that only the second stage is read.
 */
`timescale 1ns/1ps
`default_nettype none

module cbt_sync (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Asynchronous pin and its synchronised copy.
	input wire logic pin_in,
	output logic pin_sync
);

	logic meta_q;
	logic stable_q;

	// Both stages reset recessive so no false edge is seen after reset.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_q <= 1'b1;
			stable_q <= 1'b1;
		end else if (clk_en) begin
			meta_q <= pin_in;
			stable_q <= meta_q;
		end
	end

	assign pin_sync = stable_q;

endmodule
`default_nettype wire

// file: logic/cbt_quantum.sv
/*
 * Time quantum generator: divides the core clock by the baud prescaler plus one.
 * Assumes the prescaler is static while run is high.
 */
`timescale 1ns/1ps
`default_nettype none

module cbt_quantum (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Control.
	input wire logic run,
	input wire logic [5:0] baud_prescaler,
	// Strobes, one core cycle wide.
	output logic tq_tick,
	output logic half_tick
);

	logic [5:0] div_q;

	// The divider restarts whenever the controller stops, so every bit starts on a clean quantum.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			div_q <= cbt_pkg::DIV_RESET;
		end else if (clk_en) begin
			if (!run || tq_tick) begin
				div_q <= cbt_pkg::DIV_RESET;
			end else begin
				div_q <= div_q + 6'h01;
			end
		end
	end

	// A quantum lasts prescaler plus one core cycles.
	assign tq_tick = run && (div_q == baud_prescaler);
	// With a prescaler of zero the middle strobe coincides with the end strobe.
	assign half_tick = run && (div_q == {1'b0, baud_prescaler[5:1]});

endmodule
`default_nettype wire

// file: logic/cbt_core.sv
/*
 * CAN bit timing engine and message object register window.
 * Assumes a frame engine on the same clock supplies events and the transmit bit,
 * and that the receive pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module cbt_core (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Special function register port.
	input wire cbt_pkg::cbt_sfr_type sfr_req,
	output logic [7:0] sfr_rdata,
	// Controller settings held outside this block.
	input wire logic controller_enable,
	input wire logic [5:0] baud_prescaler,
	input wire logic abort_request,
	// CAN pins.
	input wire logic can_rx_pin,
	output logic can_tx_pin,
	// Bit stream towards the frame engine.
	input wire logic tx_bit,
	output logic bit_start,
	output logic sample_strobe,
	output logic sampled_bit,
	// Object events and queries from the frame engine.
	input wire cbt_pkg::cbt_event_type evt,
	input wire logic [3:0] query_obj,
	output logic [1:0] query_cfg,
	output logic query_reply_ok,
	output logic query_extended,
	output logic query_enabled,
	output logic [14:0] enable_bits
);

	cbt_pkg::cbt_page_type page_q;
	cbt_pkg::cbt_jump_type jump_q;
	cbt_pkg::cbt_phase_type phase_q;
	cbt_pkg::cbt_control_type ctrl_q [cbt_pkg::NUM_OBJECTS];
	cbt_pkg::cbt_status_type stat_q [cbt_pkg::NUM_OBJECTS];
	logic [7:0] data_mem [cbt_pkg::NUM_OBJECTS][cbt_pkg::DATA_BYTES];
	logic [14:0] en_q;
	cbt_pkg::cbt_seg_type seg_q;
	logic [3:0] cnt_q;
	logic [2:0] ext_q;
	logic [3:0] ph2_end_q;
	logic resynced_q;
	logic edge_q;
	logic rx_prev_q;
	logic smp_a_q;
	logic smp_b_q;
	logic sampled_q;
	logic tx_q;
	logic [7:0] rdata_q;
	logic [1:0] qcfg_q;
	logic qreply_q;
	logic qext_q;
	logic qen_q;
	logic rx_s;
	logic tq_tick;
	logic half_tick;
	logic obj_ok;
	logic data_access;
	logic edge_now;
	logic resync_now;
	logic [2:0] sjw_q;
	logic [4:0] elapsed;
	logic [2:0] ext_calc;
	logic [3:0] ph1_end;
	logic [3:0] ph2_rem;
	logic ph2_jump;
	logic sample_point;
	logic majority;

	// Receive pin crossing into the core clock.
	cbt_sync u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.pin_in(can_rx_pin),
		.pin_sync(rx_s)
	);

	// Quantum strobes only run while the controller is enabled.
	cbt_quantum u_quantum (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.run(controller_enable),
		.baud_prescaler(baud_prescaler),
		.tq_tick(tq_tick),
		.half_tick(half_tick)
	);

	// Register access decode; object fifteen does not exist and is ignored.
	assign obj_ok = (page_q.object_number <= cbt_pkg::LAST_OBJECT);
	assign data_access = (sfr_req.wr || sfr_req.rd) && (sfr_req.addr == cbt_pkg::ADDR_DATA);

	// Page register: software write, or index step after every data byte access while increment_disable is clear.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			page_q <= cbt_pkg::PAGE_RESET;
		end else if (clk_en) begin
			if (sfr_req.wr && sfr_req.addr == cbt_pkg::ADDR_PAGE) begin
				page_q <= sfr_req.wdata;
			end else if (data_access && !page_q.increment_disable) begin
				page_q.byte_index <= page_q.byte_index + 3'h1;
			end
		end
	end

	// Timing registers; writes while enabled are dropped so a running bit never changes shape.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			jump_q <= cbt_pkg::CONTROL_RESET;
			phase_q <= cbt_pkg::CONTROL_RESET;
		end else if (clk_en && sfr_req.wr && !controller_enable) begin
			if (sfr_req.addr == cbt_pkg::ADDR_BT_JUMP) begin
				jump_q <= sfr_req.wdata & 8'h6E;
			end
			if (sfr_req.addr == cbt_pkg::ADDR_BT_PHASE) begin
				phase_q <= sfr_req.wdata & 8'h7F;
			end
		end
	end

	// Data bytes of every object; no reset, as after power-up the contents are undefined.
	always_ff @(posedge ref_clk) begin
		if (clk_en && sfr_req.wr && sfr_req.addr == cbt_pkg::ADDR_DATA && obj_ok) begin
			data_mem[page_q.object_number][page_q.byte_index] <= sfr_req.wdata;
		end
	end

	// Per-object control, status and enable. A software rewrite of the configuration beats a
	// same-cycle completion, since it is the newer request; hardware status sets beat clears.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			en_q <= 15'h0000;
			for (int i = 0; i < cbt_pkg::NUM_OBJECTS; i++) begin
				ctrl_q[i] <= cbt_pkg::CONTROL_RESET;
				stat_q[i] <= cbt_pkg::STATUS_RESET;
			end
		end else if (clk_en) begin
			for (int i = 0; i < cbt_pkg::NUM_OBJECTS; i++) begin
				if (obj_ok && page_q.object_number == 4'(i) && sfr_req.wr) begin
					if (sfr_req.addr == cbt_pkg::ADDR_CONTROL) begin
						ctrl_q[i] <= sfr_req.wdata;
					end
					if (sfr_req.addr == cbt_pkg::ADDR_STATUS) begin
						stat_q[i] <= sfr_req.wdata;
					end
				end
				if (evt.valid && evt.object_number == 4'(i)) begin
					if (evt.rx_done) begin
						ctrl_q[i].length_code <= evt.rx_length;
						stat_q[i].receive_done <= 1'b1;
						if (evt.rx_length != ctrl_q[i].length_code) begin
							stat_q[i].length_warning <= 1'b1;
						end
					end
					if (evt.tx_done) begin
						stat_q[i].transmit_done <= 1'b1;
					end
					// Only a reported error sets its flag, so a same-cycle clear of the rest lands.
					for (int b = 0; b < 5; b++) begin
						if (evt.errors[b]) begin
							stat_q[i][b] <= 1'b1;
						end
					end
				end
				if (abort_request) begin
					en_q[i] <= 1'b0;
				end else if (obj_ok && page_q.object_number == 4'(i) && sfr_req.wr
						&& sfr_req.addr == cbt_pkg::ADDR_CONTROL) begin
					en_q[i] <= (sfr_req.wdata[7:6] != cbt_pkg::CFG_DISABLE);
				end else if (evt.valid && evt.object_number == 4'(i)
						&& (evt.rx_done || evt.tx_done)) begin
					en_q[i] <= 1'b0;
				end
			end
		end
	end

	// Read data is registered and appears one cycle after the read strobe.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (clk_en && sfr_req.rd) begin
			unique case (sfr_req.addr)
				cbt_pkg::ADDR_PAGE: rdata_q <= page_q;
				cbt_pkg::ADDR_STATUS: rdata_q <= obj_ok ? stat_q[page_q.object_number] : 8'h00;
				cbt_pkg::ADDR_CONTROL: rdata_q <= obj_ok ? ctrl_q[page_q.object_number] : 8'h00;
				cbt_pkg::ADDR_BT_JUMP: rdata_q <= jump_q;
				cbt_pkg::ADDR_BT_PHASE: rdata_q <= phase_q;
				cbt_pkg::ADDR_DATA: begin
					rdata_q <= obj_ok ? data_mem[page_q.object_number][page_q.byte_index] : 8'h00;
				end
				cbt_pkg::ADDR_ENABLE_HI: rdata_q <= {1'b0, en_q[14:8]};
				cbt_pkg::ADDR_ENABLE_LO: rdata_q <= en_q[7:0];
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// Query answers for the frame engine, one cycle after the object number is presented.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			qcfg_q <= 2'h0;
			qreply_q <= 1'b0;
			qext_q <= 1'b0;
			qen_q <= 1'b0;
		end else if (clk_en) begin
			if (query_obj <= cbt_pkg::LAST_OBJECT) begin
				qcfg_q <= ctrl_q[query_obj].object_configuration;
				qreply_q <= ctrl_q[query_obj].reply_valid && en_q[query_obj];
				qext_q <= ctrl_q[query_obj].extended_id;
				qen_q <= en_q[query_obj];
			end else begin
				qcfg_q <= 2'h0;
				qreply_q <= 1'b0;
				qext_q <= 1'b0;
				qen_q <= 1'b0;
			end
		end
	end

	// Resynchronisation arithmetic: phase error in quanta, clipped to the jump width.
	assign sjw_q = {1'b0, jump_q.jump_width_field} + 3'h1;
	assign edge_now = rx_prev_q && !rx_s;
	assign resync_now = tq_tick && (edge_q || edge_now) && !resynced_q && seg_q != cbt_pkg::SEG_SYNC;
	assign elapsed = (seg_q == cbt_pkg::SEG_PROP) ? 5'({1'b0, cnt_q} + 5'h01)
		: 5'({2'b00, jump_q.propagation_field} + {1'b0, cnt_q} + 5'h02);
	assign ext_calc = (elapsed < {2'b00, sjw_q}) ? elapsed[2:0] : sjw_q;
	assign ph1_end = {1'b0, phase_q.phase_one_field}
		+ {1'b0, (resync_now && seg_q != cbt_pkg::SEG_PH2) ? ext_calc : ext_q};
	assign ph2_rem = ph2_end_q - cnt_q;
	assign ph2_jump = resync_now && seg_q == cbt_pkg::SEG_PH2 && ph2_rem <= {1'b0, sjw_q};
	assign sample_point = tq_tick && seg_q == cbt_pkg::SEG_PH1 && cnt_q == ph1_end;

	// Falling edges seen within the current quantum; only recessive-to-dominant counts.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rx_prev_q <= 1'b1;
			edge_q <= 1'b0;
		end else if (clk_en) begin
			rx_prev_q <= rx_s;
			if (tq_tick) begin
				edge_q <= 1'b0;
			end else if (edge_now) begin
				edge_q <= 1'b1;
			end
		end
	end

	// Bit segment sequencer; one resynchronisation per bit keeps the jump bounded.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			seg_q <= cbt_pkg::SEG_SYNC;
			cnt_q <= cbt_pkg::COUNT_RESET;
			ext_q <= cbt_pkg::EXT_RESET;
			ph2_end_q <= cbt_pkg::COUNT_RESET;
			resynced_q <= 1'b0;
		end else if (clk_en) begin
			if (!controller_enable) begin
				seg_q <= cbt_pkg::SEG_SYNC;
				cnt_q <= cbt_pkg::COUNT_RESET;
				ext_q <= cbt_pkg::EXT_RESET;
				resynced_q <= 1'b0;
			end else if (tq_tick) begin
				if (resync_now) begin
					resynced_q <= 1'b1;
				end
				unique case (seg_q)
					cbt_pkg::SEG_SYNC: begin
						seg_q <= cbt_pkg::SEG_PROP;
						cnt_q <= cbt_pkg::COUNT_RESET;
						ext_q <= cbt_pkg::EXT_RESET;
						resynced_q <= 1'b0;
						ph2_end_q <= {1'b0, phase_q.phase_two_field};
					end
					cbt_pkg::SEG_PROP: begin
						if (resync_now) begin
							ext_q <= ext_calc;
						end
						if (cnt_q == {1'b0, jump_q.propagation_field}) begin
							seg_q <= cbt_pkg::SEG_PH1;
							cnt_q <= cbt_pkg::COUNT_RESET;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
					cbt_pkg::SEG_PH1: begin
						if (resync_now) begin
							ext_q <= ext_calc;
						end
						if (cnt_q == ph1_end) begin
							seg_q <= cbt_pkg::SEG_PH2;
							cnt_q <= cbt_pkg::COUNT_RESET;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
					cbt_pkg::SEG_PH2: begin
						if (ph2_jump) begin
							seg_q <= cbt_pkg::SEG_PROP;
							cnt_q <= cbt_pkg::COUNT_RESET;
							ext_q <= cbt_pkg::EXT_RESET;
							resynced_q <= 1'b0;
							ph2_end_q <= {1'b0, phase_q.phase_two_field};
						end else if (cnt_q == (resync_now ? ph2_end_q - {1'b0, sjw_q} : ph2_end_q)) begin
							seg_q <= cbt_pkg::SEG_SYNC;
						end else begin
							if (resync_now) begin
								ph2_end_q <= ph2_end_q - {1'b0, sjw_q};
							end
							cnt_q <= cnt_q + 4'h1;
						end
					end
				endcase
			end
		end
	end

	// Majority of the quantum-start, mid-quantum and sample-point values.
	assign majority = (smp_a_q && smp_b_q) || (smp_a_q && rx_s) || (smp_b_q && rx_s);

	// Bus sampling and transmit pin; the pin rests recessive while the controller is off.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			smp_a_q <= 1'b1;
			smp_b_q <= 1'b1;
			sampled_q <= 1'b1;
			tx_q <= 1'b1;
		end else if (clk_en) begin
			if (tq_tick) begin
				smp_a_q <= rx_s;
			end
			if (half_tick) begin
				smp_b_q <= rx_s;
			end
			if (sample_point) begin
				sampled_q <= phase_q.sample_type ? majority : rx_s;
			end
			if (!controller_enable) begin
				tx_q <= 1'b1;
			end else if (bit_start) begin
				tx_q <= tx_bit;
			end
		end
	end

	// Output drive.
	assign bit_start = tq_tick && (seg_q == cbt_pkg::SEG_SYNC || ph2_jump);
	assign sample_strobe = sample_point;
	assign sampled_bit = sampled_q;
	assign can_tx_pin = tx_q;
	assign sfr_rdata = rdata_q;
	assign query_cfg = qcfg_q;
	assign query_reply_ok = qreply_q;
	assign query_extended = qext_q;
	assign query_enabled = qen_q;
	assign enable_bits = en_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_data_access;
		clk_en && data_access && !page_q.increment_disable;
	endsequence

	a_index_advance: assert property (s_data_access |=>
		page_q.byte_index == 3'($past(page_q.byte_index) + 3'h1)) else $error("index did not advance");
	a_index_hold: assert property (clk_en && data_access && page_q.increment_disable
		|=> $stable(page_q.byte_index)) else $error("index moved while disabled");
	a_index_wrap: assert property (s_data_access ##0 page_q.byte_index == 3'h7
		|=> page_q.byte_index == 3'h0) else $error("index did not wrap");
	a_sync_length: assert property (clk_en && controller_enable && tq_tick
		&& seg_q == cbt_pkg::SEG_SYNC |=> seg_q == cbt_pkg::SEG_PROP) else $error("sync not one quantum");
	a_prop_exit: assert property (clk_en && controller_enable && tq_tick && seg_q == cbt_pkg::SEG_PROP
		&& cnt_q == {1'b0, jump_q.propagation_field} |=> seg_q == cbt_pkg::SEG_PH1) else $error("prop length");
	a_ph1_exit: assert property (clk_en && controller_enable && sample_point
		|=> seg_q == cbt_pkg::SEG_PH2 && cnt_q == 4'h0) else $error("phase one length");
	a_ext_bound: assert property (ext_q <= sjw_q) else $error("extension beyond jump width");
	a_sample_once: assert property (clk_en && sample_point && !phase_q.sample_type
		|=> sampled_bit == $past(rx_s)) else $error("single sample wrong");
	a_sample_vote: assert property (clk_en && sample_point && phase_q.sample_type
		|=> sampled_bit == $past(majority)) else $error("majority sample wrong");
	a_length_update: assert property (clk_en && evt.valid && evt.rx_done
		&& evt.object_number <= cbt_pkg::LAST_OBJECT
		|=> ctrl_q[$past(evt.object_number)].length_code == $past(evt.rx_length))
		else $error("length not updated");
	a_length_warn: assert property (clk_en && evt.valid && evt.rx_done
		&& evt.object_number <= cbt_pkg::LAST_OBJECT
		&& evt.rx_length != ctrl_q[evt.object_number].length_code
		|=> stat_q[$past(evt.object_number)].length_warning) else $error("warning missing");
	a_enable_drop: assert property (clk_en && abort_request |=> en_q == 15'h0000)
		else $error("abort kept an object enabled");

endmodule
`default_nettype wire

// file: sim/cbt_node_model.sv
/* Model of the other CAN nodes: one remote node on a wired-AND bus with our transmitter.
   Assumes the bench sets the level that the remote node drives. */
`timescale 1ns/1ps
`default_nettype none

module cbt_node_model (
	// Our transmitter and the remote node level.
	input wire logic tx_pin,
	input wire logic node_bit,
	// Bus level seen by our receiver.
	output logic rx_pin
);
	// Dominant (0) from either node wins; the idle bus rests recessive, never floating.
	assign rx_pin = tx_pin & node_bit;
endmodule

`default_nettype wire

// file: sim/tb.sv
/* Self-checking bench for cbt_core: page window, object control, events and bit timing.
   Assumes the wired-AND bus model on the CAN pins and a 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none

module tb;
	// Stimulus, responses and bench state.
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	cbt_pkg::cbt_sfr_type sfr_req = '0;
	cbt_pkg::cbt_event_type evt = '0;
	logic controller_enable = 1'b0;
	logic abort_request = 1'b0;
	logic tx_bit = 1'b1;
	logic node_bit = 1'b1;
	logic [5:0] baud_prescaler = 6'h00;
	logic [3:0] query_obj = 4'h0;
	logic can_rx_pin, can_tx_pin, bit_start, sample_strobe, sampled_bit;
	logic query_reply_ok, query_extended, query_enabled;
	logic [1:0] query_cfg;
	logic [14:0] enable_bits;
	logic [7:0] sfr_rdata, q;
	logic [7:0] mem [8];
	logic [31:0] rnd;
	integer seed = 20290;
	integer error_cnt = 0;
	integer total_checks = 0;
	integer n, i;

	// Design under test and the far-side bus.
	cbt_core i_cbt_core (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .controller_enable(controller_enable),
		.baud_prescaler(baud_prescaler), .abort_request(abort_request),
		.can_rx_pin(can_rx_pin), .can_tx_pin(can_tx_pin), .tx_bit(tx_bit),
		.bit_start(bit_start), .sample_strobe(sample_strobe), .sampled_bit(sampled_bit),
		.evt(evt), .query_obj(query_obj), .query_cfg(query_cfg),
		.query_reply_ok(query_reply_ok), .query_extended(query_extended),
		.query_enabled(query_enabled), .enable_bits(enable_bits));
	cbt_node_model i_cbt_node_model (.tx_pin(can_tx_pin), .node_bit(node_bit),
		.rx_pin(can_rx_pin));

	// Clock of 40 ns period.
	always #20 ref_clk = ~ref_clk;

	// Compares one value and counts it.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One register access; read data is taken at the edge after the taking edge, where it stands.
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge ref_clk);
		sfr_req <= '0;
		@(posedge ref_clk);
		q = sfr_rdata;
	endtask

	// Reports one object event from the frame engine side.
	task automatic send_evt(input logic [3:0] o, input logic rx, input logic tx,
		input logic [4:0] e, input logic [3:0] l);
		@(posedge ref_clk);
		evt <= '{1'b1, o, rx, tx, e, l};
		@(posedge ref_clk);
		evt <= '0;
	endtask

	// Counts cycles up to the next bit start or sample strobe, bounded so a hang ends.
	task automatic wait_for(input logic strobe);
		n = 0;
		do begin
			@(posedge ref_clk);
			n = n + 1;
		end while ((strobe ? sample_strobe : bit_start) !== 1'b1 && n < 800);
		if (n >= 800) begin
			error_cnt = error_cnt + 1;
			$display("Error at %0t: strobe never came", $time);
		end
	endtask

	// Nominal bit length in core cycles.
	function automatic logic [15:0] bit_len(input logic [2:0] p, input logic [2:0] a,
		input logic [2:0] b, input logic [1:0] r);
		return 16'(4 + p + a + b) * 16'(r + 1);
	endfunction

	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		acc(0, cbt_pkg::ADDR_PAGE, 8'h00);
		chk(q, cbt_pkg::PAGE_RESET);
		acc(1, cbt_pkg::ADDR_PAGE, 8'h26);
		acc(1, cbt_pkg::ADDR_DATA, 8'hA6);
		acc(1, cbt_pkg::ADDR_DATA, 8'hA7);
		acc(0, cbt_pkg::ADDR_PAGE, 8'h00);
		chk(q, 8'h20);
		for (i = 0; i < 8; i++) begin
			rnd = $random(seed);
			mem[i] = rnd[7:0];
			acc(1, cbt_pkg::ADDR_DATA, mem[i]);
		end
		for (i = 0; i < 8; i++) begin
			acc(0, cbt_pkg::ADDR_DATA, 8'h00);
			chk(q, mem[i]);
		end
		acc(1, cbt_pkg::ADDR_PAGE, 8'h2B);
		acc(0, cbt_pkg::ADDR_DATA, 8'h00);
		acc(0, cbt_pkg::ADDR_DATA, 8'h00);
		chk(q, mem[3]);
		acc(0, cbt_pkg::ADDR_PAGE, 8'h00);
		chk(q, 8'h2B);
		acc(1, cbt_pkg::ADDR_PAGE, 8'hF0);
		acc(0, cbt_pkg::ADDR_CONTROL, 8'h00);
		chk(q, 8'h00);
		// A write while the clock enable is low must leave the page alone.
		clk_en <= 1'b0;
		acc(1, cbt_pkg::ADDR_PAGE, 8'h77);
		clk_en <= 1'b1;
		acc(0, cbt_pkg::ADDR_PAGE, 8'h00);
		chk(q, 8'hF0);
		$display("page window done");
		// Every configuration code, rewritten each time so the enable bit is set for every code but disable.
		acc(1, cbt_pkg::ADDR_PAGE, 8'h50);
		query_obj <= 4'h5;
		for (i = 0; i < 4; i++) begin
			acc(1, cbt_pkg::ADDR_CONTROL, {i[1:0], 1'b1, i[0], 4'h8});
			acc(0, cbt_pkg::ADDR_CONTROL, 8'h00);
			chk(q, {i[1:0], 1'b1, i[0], 4'h8});
			chk(enable_bits[5], i != 0);
			chk(query_cfg, i[1:0]);
			chk(query_reply_ok, i != 0);
			chk(query_extended, i[0]);
			chk(query_enabled, i != 0);
		end
		@(posedge ref_clk);
		abort_request <= 1'b1;
		@(posedge ref_clk);
		abort_request <= 1'b0;
		@(posedge ref_clk);
		chk(enable_bits, 15'h0000);
		// Completion events: receive with a short length, transmit with errors.
		acc(1, cbt_pkg::ADDR_PAGE, 8'h30);
		acc(1, cbt_pkg::ADDR_CONTROL, 8'h88);
		chk(enable_bits[3], 1'b1);
		send_evt(4'h3, 1'b1, 1'b0, 5'h00, 4'h5);
		acc(0, cbt_pkg::ADDR_CONTROL, 8'h00);
		chk(q, 8'h85);
		acc(0, cbt_pkg::ADDR_STATUS, 8'h00);
		chk(q, 8'hA0);
		chk(enable_bits[3], 1'b0);
		acc(1, cbt_pkg::ADDR_PAGE, 8'h40);
		acc(1, cbt_pkg::ADDR_CONTROL, 8'h48);
		send_evt(4'h4, 1'b0, 1'b1, 5'h12, 4'h8);
		acc(0, cbt_pkg::ADDR_STATUS, 8'h00);
		chk(q, 8'h52);
		chk(enable_bits[4], 1'b0);
		$display("objects done");
		// Random bit timings; phase two is kept at least phase one and two quanta.
		for (i = 0; i < 3; i++) begin
			rnd = $random(seed);
			if (rnd[6:4] < rnd[3:1])
				rnd[6:4] = rnd[3:1];
			if (rnd[6:4] == 3'h0)
				rnd[6:4] = 3'h1;
			rnd[0] = i[0];
			baud_prescaler <= {4'h0, rnd[17:16]};
			acc(1, cbt_pkg::ADDR_BT_JUMP, {1'b0, rnd[14:13], 1'b0, rnd[11:9], 1'b0});
			acc(1, cbt_pkg::ADDR_BT_PHASE, {1'b0, rnd[6:0]});
			acc(0, cbt_pkg::ADDR_BT_PHASE, 8'h00);
			chk(q, {1'b0, rnd[6:0]});
			controller_enable <= 1'b1;
			wait_for(1'b0);
			wait_for(1'b0);
			chk(n[15:0], bit_len(rnd[11:9], rnd[3:1], rnd[6:4], rnd[17:16]));
			node_bit <= 1'b0;
			wait_for(1'b1);
			wait_for(1'b1);
			@(posedge ref_clk);
			chk(sampled_bit, 1'b0);
			node_bit <= 1'b1;
			wait_for(1'b1);
			wait_for(1'b1);
			@(posedge ref_clk);
			chk(sampled_bit, 1'b1);
			// Our own dominant bit comes back through the bus; the loop delay is the two synchroniser cycles.
			tx_bit <= 1'b0;
			wait_for(1'b0);
			wait_for(1'b1);
			wait_for(1'b1);
			@(posedge ref_clk);
			chk(sampled_bit, 1'b0);
			chk(can_tx_pin, 1'b0);
			tx_bit <= 1'b1;
			acc(1, cbt_pkg::ADDR_BT_JUMP, 8'h7E);
			controller_enable <= 1'b0;
			acc(0, cbt_pkg::ADDR_BT_JUMP, 8'h00);
			chk(q, {1'b0, rnd[14:13], 1'b0, rnd[11:9], 1'b0});
			chk(can_tx_pin, 1'b1);
		end
		$display("bit timing done");
		final_report();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#(40 * 20000);
		error_cnt = error_cnt + 1;
		final_report();
	end
endmodule

`default_nettype wire
